// >>> dbtc_done_queue.sv
// completion queue holding finished outbound doorbells
`timescale 1ns/1ps
module dbtc_done_queue
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic push_i,
   input wire dbtc_pkg::dbtc_entry_t push_data_i,
   input wire logic pop_i,
   output dbtc_pkg::dbtc_entry_t head_o,
   output logic [dbtc_pkg::LVL_W-1:0] level_o,
   output logic overflow_o
);
   dbtc_pkg::dbtc_entry_t mem [dbtc_pkg::QUEUE_DEPTH];
   logic [3:0] wr_ptr_reg;
   logic [3:0] rd_ptr_reg;
   logic [dbtc_pkg::LVL_W-1:0] level_reg;
   logic full;
   logic empty;
   logic do_push;
   logic do_pop;

   assign full = (level_reg == dbtc_pkg::LVL_W'(dbtc_pkg::QUEUE_DEPTH));
   assign empty = (level_reg == '0);
   assign do_pop = pop_i && !empty;
   assign do_push = push_i && (!full || do_pop);
   assign overflow_o = push_i && full && !do_pop;
   assign head_o = mem[rd_ptr_reg];
   assign level_o = level_reg;

   always_ff @(posedge core_clk_i)
   begin
      if (do_push)
      begin
         mem[wr_ptr_reg] <= push_data_i;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         wr_ptr_reg <= 4'h0;
         rd_ptr_reg <= 4'h0;
         level_reg <= '0;
      end
      else
      begin
         if (do_push)
         begin
            wr_ptr_reg <= wr_ptr_reg + 4'h1;
         end
         if (do_pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + 4'h1;
         end
         if (do_push && !do_pop)
         begin
            level_reg <= level_reg + 5'h1;
         end
         else if (do_pop && !do_push)
         begin
            level_reg <= level_reg - 5'h1;
         end
      end
   end
endmodule // dbtc_done_queue

// >>> dbtc_far_end.sv
// far-end model returning doorbell outcomes
`timescale 1ns/1ps
module dbtc_far_end
(
   input wire logic core_clk_i,
   output logic done_valid_o,
   output dbtc_pkg::dbtc_entry_t done_data_o
);
   initial
   begin
      done_valid_o = 1'b0;
      done_data_o = '0;
   end
   // answer after gap+1 idle cycles; data scrambled once released
   task automatic answer(input dbtc_pkg::dbtc_entry_t e, input int gap);
      repeat (gap + 1) @(posedge core_clk_i);
      done_valid_o <= 1'b1;
      done_data_o <= e;
      @(posedge core_clk_i);
      done_valid_o <= 1'b0;
      done_data_o <= ~e;
   endtask
endmodule // dbtc_far_end

// >>> dbtc_pkg.sv
// package for the doorbell transmit completion register bank
package dbtc_pkg;
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFF_QUEUE_STATUS = 6'h10;
   localparam logic [5:0] OFF_COMPLETION_ENTRY = 6'h14;
   localparam logic [5:0] OFF_OUTCOME = 6'h18;
   localparam logic [5:0] OFF_CAPTURE_CTRL = 6'h1c;
   localparam logic [5:0] OFF_IRQ_ENABLE = 6'h20;
   localparam logic [5:0] OFF_IRQ_FLAGS = 6'h24;
   localparam int PEND_LSB = 16;
   localparam int SENDQ_LSB = 8;
   localparam int DONEQ_LSB = 0;
   localparam int CAP_ERR_BIT = 1;
   localparam int CAP_OK_BIT = 0;
   localparam int IRQ_OVF_BIT = 2;
   localparam int IRQ_DONE_BIT = 1;
   localparam int IRQ_RX_BIT = 0;
   localparam int QUEUE_DEPTH = 16;
   localparam int LVL_W = 5;
   localparam logic [1:0] OUT_DONE = 2'h0;
   localparam logic [1:0] OUT_ERROR = 2'h1;
   localparam logic [1:0] OUT_TIMEOUT = 2'h2;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam logic [31:0] RDATA_RESET = 32'h0;

   typedef struct packed {
      logic [7:0] target_node_id;
      logic [15:0] payload;
      logic [1:0] outcome;
   } dbtc_entry_t;
endpackage

// >>> dbtc_regs_assertions.sv
// port assertions for the doorbell completion register bank
`timescale 1ns/1ps
module dbtc_chk
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [5:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [31:0] readdata_o,
   input wire logic [4:0] pending_count_i,
   input wire logic [4:0] send_queue_count_i,
   input wire logic done_valid_i,
   input wire dbtc_pkg::dbtc_entry_t done_data_i,
   input wire logic rx_doorbell_i,
   input wire logic [2:0] capture_ctrl_o,
   input wire logic irq_o
);
   logic [2:0] en_reg;
   logic st, ok, dv;
   logic [1:0] wd;
   assign st = read_i && address_i == dbtc_pkg::OFF_QUEUE_STATUS;
   assign ok = done_data_i.outcome == dbtc_pkg::OUT_DONE;
   assign dv = done_valid_i && !rx_doorbell_i && !write_i;
   assign wd = writedata_i[1:0];
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         en_reg <= 3'h0;
      end
      else if (write_i && address_i == dbtc_pkg::OFF_IRQ_ENABLE)
      begin
         en_reg <= writedata_i[2:0];
      end
   end
   property p_pend; st |=> readdata_o[23:16] == {3'h0, $past(pending_count_i)}; endproperty
   a_pend: assert property (p_pend) else $error("bad pending");
   property p_send; st |=> readdata_o[15:8] == {3'h0, $past(send_queue_count_i)}; endproperty
   a_send: assert property (p_send) else $error("bad send count");
   property p_ctrl; write_i && address_i == 6'h1c |=> capture_ctrl_o == {1'b0, $past(wd)}; endproperty
   a_ctrl: assert property (p_ctrl) else $error("bad capture");
   property p_ok; dv && ok && capture_ctrl_o[0] && en_reg[1] |=> irq_o; endproperty
   a_ok: assert property (p_ok) else $error("success lost");
   property p_err; dv && !ok && capture_ctrl_o[1] && en_reg[1] |=> irq_o; endproperty
   a_err: assert property (p_err) else $error("failure lost");
   property p_drop; dv && capture_ctrl_o == 3'h0 && en_reg == 3'h2 && !irq_o |=> !irq_o; endproperty
   a_drop: assert property (p_drop) else $error("drop flagged");
   property p_rx; rx_doorbell_i && en_reg[0] |=> irq_o; endproperty
   a_rx: assert property (p_rx) else $error("receive lost");
   property p_clr;
      write_i && address_i == 6'h24 && wd[1] && en_reg == 3'h2 && !done_valid_i |=> !irq_o;
   endproperty
   a_clr: assert property (p_clr) else $error("clear failed");
   c_ok: cover property (dv && en_reg[1]);
   c_rx: cover property (rx_doorbell_i && en_reg[0]);
   c_st: cover property (st);
   c_ovf: cover property (en_reg[2] && irq_o);
endmodule // dbtc_chk
bind doorbell_tx_completion_regs dbtc_chk u_chk (.*);

// >>> doorbell_tx_completion_regs.sv
// doorbell transmit status, completion readout and interrupt registers
`timescale 1ns/1ps
module doorbell_tx_completion_regs
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [dbtc_pkg::ADDR_W-1:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   input wire logic [dbtc_pkg::LVL_W-1:0] pending_count_i,
   input wire logic [dbtc_pkg::LVL_W-1:0] send_queue_count_i,
   input wire logic done_valid_i,
   input wire dbtc_pkg::dbtc_entry_t done_data_i,
   input wire logic rx_doorbell_i,
   output logic [2:0] capture_ctrl_o,
   output logic irq_o
);
   logic [1:0] capture_reg;
   logic [2:0] irq_en_reg;
   logic [2:0] irq_flag_reg;
   logic [2:0] irq_flag_next;
   logic [1:0] outcome_reg;
   logic [31:0] readdata_reg;
   logic [31:0] readdata_next;
   logic irq_reg;
   logic popped_since_ovf_reg;
   logic keep;
   logic push;
   logic pop;
   logic overflow;
   logic is_ok;
   logic [dbtc_pkg::LVL_W-1:0] done_level;
   dbtc_pkg::dbtc_entry_t head;

   assign is_ok = (done_data_i.outcome == dbtc_pkg::OUT_DONE);
   assign keep = is_ok ? capture_reg[dbtc_pkg::CAP_OK_BIT]
                       : capture_reg[dbtc_pkg::CAP_ERR_BIT];
   assign push = done_valid_i && keep;
   assign pop = read_i && (address_i == dbtc_pkg::OFF_COMPLETION_ENTRY)
                && (done_level != '0);

   dbtc_done_queue u_done_queue
   (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .push_i(push),
      .push_data_i(done_data_i),
      .pop_i(pop),
      .head_o(head),
      .level_o(done_level),
      .overflow_o(overflow)
   );

   // which finished doorbells are kept
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         capture_reg <= dbtc_pkg::CTRL_RESET;
      end
      else if (write_i && (address_i == dbtc_pkg::OFF_CAPTURE_CTRL))
      begin
         capture_reg <= writedata_i[1:0];
      end
   end

   // interrupt enables
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         irq_en_reg <= dbtc_pkg::IRQ_RESET;
      end
      else if (write_i && (address_i == dbtc_pkg::OFF_IRQ_ENABLE))
      begin
         irq_en_reg <= writedata_i[2:0];
      end
   end

   // outcome of the entry popped most recently
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         outcome_reg <= dbtc_pkg::OUT_DONE;
      end
      else if (pop)
      begin
         outcome_reg <= head.outcome;
      end
   end

   // overflow flag may only clear once an entry was read after it set
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         popped_since_ovf_reg <= 1'b0;
      end
      else if (overflow)
      begin
         popped_since_ovf_reg <= 1'b0;
      end
      else if (pop)
      begin
         popped_since_ovf_reg <= 1'b1;
      end
   end

   always_comb
   begin
      irq_flag_next = irq_flag_reg;
      if (write_i && (address_i == dbtc_pkg::OFF_IRQ_FLAGS))
      begin
         irq_flag_next[dbtc_pkg::IRQ_RX_BIT] = irq_flag_reg[dbtc_pkg::IRQ_RX_BIT]
            && !writedata_i[dbtc_pkg::IRQ_RX_BIT];
         irq_flag_next[dbtc_pkg::IRQ_DONE_BIT] = irq_flag_reg[dbtc_pkg::IRQ_DONE_BIT]
            && !writedata_i[dbtc_pkg::IRQ_DONE_BIT];
         if (popped_since_ovf_reg || pop)
         begin
            irq_flag_next[dbtc_pkg::IRQ_OVF_BIT] = irq_flag_reg[dbtc_pkg::IRQ_OVF_BIT]
               && !writedata_i[dbtc_pkg::IRQ_OVF_BIT];
         end
      end
      // set wins over a same-cycle clear
      if (rx_doorbell_i)
      begin
         irq_flag_next[dbtc_pkg::IRQ_RX_BIT] = 1'b1;
      end
      if (push)
      begin
         irq_flag_next[dbtc_pkg::IRQ_DONE_BIT] = 1'b1;
      end
      if (overflow)
      begin
         irq_flag_next[dbtc_pkg::IRQ_OVF_BIT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         irq_flag_reg <= dbtc_pkg::IRQ_RESET;
      end
      else
      begin
         irq_flag_reg <= irq_flag_next;
      end
   end

   // interrupt line follows flags gated by enables
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= |(irq_flag_next & irq_en_reg);
      end
   end

   always_comb
   begin
      readdata_next = 32'h0;
      unique case (address_i)
         dbtc_pkg::OFF_QUEUE_STATUS:
         begin
            readdata_next[dbtc_pkg::PEND_LSB +: 8] = 8'(pending_count_i);
            readdata_next[dbtc_pkg::SENDQ_LSB +: 8] = 8'(send_queue_count_i);
            readdata_next[dbtc_pkg::DONEQ_LSB +: 8] = 8'(done_level);
         end
         dbtc_pkg::OFF_COMPLETION_ENTRY:
         begin
            if (done_level != '0)
            begin
               readdata_next[23:0] = {head.target_node_id, head.payload};
            end
         end
         dbtc_pkg::OFF_OUTCOME:
         begin
            readdata_next[1:0] = pop ? head.outcome : outcome_reg;
         end
         dbtc_pkg::OFF_CAPTURE_CTRL: readdata_next[1:0] = capture_reg;
         dbtc_pkg::OFF_IRQ_ENABLE: readdata_next[2:0] = irq_en_reg;
         dbtc_pkg::OFF_IRQ_FLAGS: readdata_next[2:0] = irq_flag_reg;
         default: readdata_next = 32'h0;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         readdata_reg <= dbtc_pkg::RDATA_RESET;
      end
      else if (read_i)
      begin
         readdata_reg <= readdata_next;
      end
   end

   assign readdata_o = readdata_reg;
   assign capture_ctrl_o = {1'b0, capture_reg};
   assign irq_o = irq_reg;
endmodule // doorbell_tx_completion_regs

// >>> testbench.sv
// self-checking bench for the doorbell completion register bank
`timescale 1ns/1ps
module testbench;
   logic core_clk_i = 1'b0, reset_n_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
   logic rx_doorbell_i = 1'b0, done_valid_i, irq_o;
   logic [5:0] address_i = 6'h0;
   logic [31:0] writedata_i = 32'h0, readdata_o, rv;
   logic [4:0] pending_count_i = 5'h0, send_queue_count_i = 5'h10;
   logic [2:0] capture_ctrl_o;
   dbtc_pkg::dbtc_entry_t done_data_i, e, q[$];
   int miscompares = 0, checks = 0, cycles = 0, seed = 32'h60e4;
   always #25 core_clk_i = ~core_clk_i;
   dbtc_far_end far (.core_clk_i, .done_valid_o(done_valid_i), .done_data_o(done_data_i));
   doorbell_tx_completion_regs DUT (.*);
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x)
      begin
         miscompares++;
         $display("CHECK FAILED %0t %h %h", $time, s, x);
      end
   endtask
   task automatic bus(input logic r, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      address_i <= a;
      read_i <= r;
      write_i <= !r;
      writedata_i <= d;
      @(posedge core_clk_i);
      read_i <= 1'b0;
      write_i <= 1'b0;
      #1 rv = readdata_o;
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] x);
      bus(1'b1, a, 32'h0);
      chk(rv, x);
   endtask
   function automatic logic [31:0] stat();
      return {11'h0, pending_count_i, 3'h0, send_queue_count_i, 8'(q.size())};
   endfunction
   task automatic pop;
      e = q.pop_front();
      rdc(6'h14, {8'h0, e.target_node_id, e.payload});
      rdc(6'h18, {30'h0, e.outcome});
   endtask
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge core_clk_i)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         miscompares++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (16) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      for (int a = 12; a <= 36; a += 4)
         rdc(6'(a), {16'h0, a == 16 ? 8'h10 : 8'h0, 8'h0});
      @(posedge core_clk_i);
      pending_count_i <= 5'($unsigned($random(seed)) % 17);
      send_queue_count_i <= 5'($unsigned($random(seed)) % 17);
      #1 rdc(6'h10, stat());
      bus(1'b0, 6'h20, 32'h2);
      rdc(6'h20, 32'h2);
      for (int m = 0; m < 4; m++)
      begin
         bus(1'b0, 6'h1c, m);
         chk(capture_ctrl_o, m);
         for (int k = 0; k < 4; k++)
         begin
            e = {8'($random(seed)), 16'($random(seed)), 2'(k)};
            far.answer(e, $unsigned($random(seed)) % 4);
            if (k == 0 ? m[0] : m[1])
               q.push_back(e);
         end
         rdc(6'h10, stat());
         chk(irq_o, q.size() != 0);
         bus(1'b0, 6'h24, 32'h2);
         chk(irq_o, 1'b0);
         while (q.size() != 0)
            pop();
      end
      rdc(6'h14, 32'h0);
      bus(1'b0, 6'h20, 32'h1);
      @(posedge core_clk_i);
      rx_doorbell_i <= 1'b1;
      @(posedge core_clk_i);
      rx_doorbell_i <= 1'b0;
      rdc(6'h24, 32'h1);
      chk(irq_o, 1'b1);
      bus(1'b0, 6'h24, 32'h1);
      chk(irq_o, 1'b0);
      bus(1'b0, 6'h20, 32'h4);
      bus(1'b0, 6'h1c, 32'h1);
      for (int i = 0; i < 17; i++)
      begin
         e = {8'(i), 16'($random(seed)), 2'h0};
         far.answer(e, 0);
         if (i < 16)
            q.push_back(e);
      end
      rdc(6'h10, stat());
      rdc(6'h24, 32'h6);
      bus(1'b0, 6'h24, 32'h4);
      rdc(6'h24, 32'h6);
      chk(irq_o, 1'b1);
      pop();
      bus(1'b0, 6'h24, 32'h6);
      chk(irq_o, 1'b0);
      while (q.size() != 0)
         pop();
      give_verdict();
   end
endmodule // testbench
